// [verilog/e1bti_pkg.sv]
// constants for the e1 backplane timing and transmit input block
package e1bti_pkg;
  localparam int E1BTI_NCH = 4;
  localparam int E1BTI_POS_W = 8;
  localparam int E1BTI_MUX_W = 11;
  localparam int E1BTI_CTRL_W = 4;
  // apb byte addresses
  localparam logic [7:0] E1BTI_CTRL_ADDR = 8'h00;
  localparam logic [7:0] E1BTI_STAT_ADDR = 8'h04;
  localparam logic [7:0] E1BTI_POS_ADDR = 8'h08;
  // control register fields
  localparam int E1BTI_CTRL_BYPASS = 0;
  localparam int E1BTI_CTRL_RCKSEL = 1;
  localparam int E1BTI_CTRL_RXREC = 2;
  localparam int E1BTI_CTRL_DUAL = 3;
  localparam logic [3:0] E1BTI_CTRL_RST = 4'h0;
  // status register fields
  localparam int E1BTI_STAT_MUX = 0;
  localparam int E1BTI_STAT_MUXN = 1;
  localparam int E1BTI_STAT_TXAL = 4;
  localparam int E1BTI_STAT_RXAL = 8;
  // position register fields
  localparam int E1BTI_POS_RX = 0;
  localparam int E1BTI_POS_MRX = 16;
  // mux slot layout: bits 1:0 channel, bit 2 signaling, 10:3 bit number
  localparam int E1BTI_SLOT_SIG = 2;
  localparam logic [10:0] E1BTI_MUX_RST = 11'h000;
  localparam logic [7:0] E1BTI_POS_RST = 8'h00;
  // positions of the asynchronous inputs in the synchroniser vector
  localparam int E1BTI_SYN_W = 30;
  localparam int E1BTI_SI_REC = 0;
  localparam int E1BTI_SI_TCLK = 4;
  localparam int E1BTI_SI_PCM = 8;
  localparam int E1BTI_SI_SIG = 12;
  localparam int E1BTI_SI_NEG = 16;
  localparam int E1BTI_SI_TFP = 20;
  localparam int E1BTI_SI_RCLK = 24;
  localparam int E1BTI_SI_RFP = 25;
  localparam int E1BTI_SI_MRXCK = 26;
  localparam int E1BTI_SI_MRFP = 27;
  localparam int E1BTI_SI_MREQ = 28;
  localparam int E1BTI_SI_MTXCK = 29;
endpackage : e1bti_pkg

// [verilog/e1bti_sync.sv]
// two-flop synchroniser with rising edge detect for the backplane pins
module e1bti_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // meta_q feeds sync_q only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
endmodule : e1bti_sync

// [verilog/e1bti_top.sv]
// backplane receive timing, transmit data inputs and mux stream handling
// Contract
// - with store bypass or clock select set, channel may use recovered clock
// - mux mode: 16.384MHz clock; frame pulse sampled, output updated on rise
// - mux mode is unavailable with store bypass or recovered clock select
// - single-rail: transmit data sampled on rising channel transmit clock
// - dual-rail: both rails sampled on rising clock, sent to jitter attenuator
// - mux mode ignores every negative-rail transmit input
// - mux mode: channel one data pin is the stream, pins two-four ignored
// - mux stream interleaves four channels' pcm and signaling; device splits it
// - mux data sampled on rising mux clock, aligned by mux frame pulse
// - signaling bits 5-8 aligned to data, sampled on rising transmit clock
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module e1bti_top
  import e1bti_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mux_enable_n,
  input wire logic bp_rx_clock,
  input wire logic bp_rx_frame_pulse_in,
  input wire logic mux_rx_clock,
  input wire logic mux_rx_frame_pulse,
  input wire logic [3:0] recovered_line_clock_out,
  input wire logic [3:0] rx_pcm_data,
  input wire logic [3:0] rx_sig_data,
  input wire logic [3:0] bp_tx_clock,
  input wire logic [3:0] bp_tx_pcm_in,
  input wire logic [3:0] bp_tx_signaling_in,
  input wire logic [3:0] bp_tx_neg_rail,
  input wire logic [3:0] bp_tx_frame_pulse,
  input wire logic mux_tx_clock,
  output logic mux_rx_serial_out,
  output logic mux_mode,
  output logic [3:0] rx_bit_strobe,
  output logic [3:0][7:0] rx_bit_pos,
  output logic [3:0] tx_strobe,
  output logic [3:0] tx_data,
  output logic [3:0] tx_sig,
  output logic [3:0][7:0] tx_bit_pos,
  output logic [3:0] dj_strobe,
  output logic [3:0] dj_pos_rail,
  output logic [3:0] dj_neg_rail
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [E1BTI_SYN_W-1:0] pins_w;
  logic [E1BTI_SYN_W-1:0] lvl_w;
  logic [E1BTI_SYN_W-1:0] rise_w;

  // mux request kept active high: a cleared synchroniser reads as no request
  assign pins_w = {mux_tx_clock, ~mux_enable_n, mux_rx_frame_pulse,
                   mux_rx_clock, bp_rx_frame_pulse_in, bp_rx_clock,
                   bp_tx_frame_pulse, bp_tx_neg_rail, bp_tx_signaling_in,
                   bp_tx_pcm_in, bp_tx_clock, recovered_line_clock_out};

  // link clocks are sampled, so the link must run well below sys_clk / 2
  e1bti_sync #(.W(E1BTI_SYN_W)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(pins_w),
    .level(lvl_w),
    .rise(rise_w)
  );

  logic [3:0] rec_rise_w, tclk_rise_w, pcm_w, sig_w, neg_w, tfp_w;
  logic rclk_rise_w, rfp_w, mrx_clk_rise_w, mrfp_w, mux_req_w, mtx_clk_rise_w;

  assign rec_rise_w = rise_w[E1BTI_SI_REC +: 4];
  assign tclk_rise_w = rise_w[E1BTI_SI_TCLK +: 4];
  assign pcm_w = lvl_w[E1BTI_SI_PCM +: 4];
  assign sig_w = lvl_w[E1BTI_SI_SIG +: 4];
  assign neg_w = lvl_w[E1BTI_SI_NEG +: 4];
  assign tfp_w = lvl_w[E1BTI_SI_TFP +: 4];
  assign rclk_rise_w = rise_w[E1BTI_SI_RCLK];
  assign rfp_w = lvl_w[E1BTI_SI_RFP];
  assign mrx_clk_rise_w = rise_w[E1BTI_SI_MRXCK];
  assign mrfp_w = lvl_w[E1BTI_SI_MRFP];
  assign mux_req_w = lvl_w[E1BTI_SI_MREQ];
  assign mtx_clk_rise_w = rise_w[E1BTI_SI_MTXCK];

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one setup cycle, answer in the first access cycle
  logic [3:0] ctrl_q, tx_aligned_q, rx_aligned_q;
  logic [31:0] prdata_q, stat_w, pos_w, rd_w;
  logic pready_q, pslverr_q, setup_w, wr_ctrl_w;
  logic hit_ctrl_w, hit_stat_w, hit_pos_w;
  logic [E1BTI_MUX_W-1:0] mrx_cnt_q;

  assign hit_ctrl_w = paddr == E1BTI_CTRL_ADDR;
  assign hit_stat_w = paddr == E1BTI_STAT_ADDR;
  assign hit_pos_w = paddr == E1BTI_POS_ADDR;
  assign setup_w = psel && !penable;
  assign wr_ctrl_w = psel && penable && pready_q && pwrite && hit_ctrl_w;
  assign stat_w = (32'(mux_mode) << E1BTI_STAT_MUX)
                | (32'(!mux_req_w) << E1BTI_STAT_MUXN)
                | (32'(tx_aligned_q) << E1BTI_STAT_TXAL)
                | (32'(rx_aligned_q) << E1BTI_STAT_RXAL);
  assign pos_w = (32'(rx_bit_pos[0]) << E1BTI_POS_RX)
               | (32'(mrx_cnt_q) << E1BTI_POS_MRX);
  assign rd_w = hit_ctrl_w ? 32'(ctrl_q) :
                hit_stat_w ? stat_w :
                hit_pos_w ? pos_w : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_w;
      pslverr_q <= setup_w && !(hit_ctrl_w || hit_stat_w || hit_pos_w);
      prdata_q <= setup_w && !pwrite ? rd_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q <= E1BTI_CTRL_RST;
    end else if (wr_ctrl_w) begin
      ctrl_q <= pwdata[E1BTI_CTRL_W-1:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // mode selection
  logic line_timed_w, use_rec_w, dual_w, mux_mode_q;

  assign line_timed_w = ctrl_q[E1BTI_CTRL_BYPASS] || ctrl_q[E1BTI_CTRL_RCKSEL];
  assign use_rec_w = line_timed_w && ctrl_q[E1BTI_CTRL_RXREC];
  assign dual_w = ctrl_q[E1BTI_CTRL_DUAL];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mux_mode_q <= 1'b0;
    end else begin
      mux_mode_q <= mux_req_w && !line_timed_w;
    end
  end

  assign mux_mode = mux_mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // mux receive stream: slot counter and serial output
  logic [E1BTI_MUX_W-1:0] mrx_next_w;
  logic [1:0] mrx_ch_w;
  logic mrx_bit_w, mrx_out_q;

  // the pulse is at most one clock wide, so its level restarts the count
  assign mrx_next_w = mrfp_w ? E1BTI_MUX_RST : mrx_cnt_q + 11'h001;
  assign mrx_ch_w = mrx_next_w[1:0];
  assign mrx_bit_w = mrx_next_w[E1BTI_SLOT_SIG] ? rx_sig_data[mrx_ch_w]
                                                : rx_pcm_data[mrx_ch_w];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mrx_cnt_q <= E1BTI_MUX_RST;
      mrx_out_q <= 1'b0;
    end else if (mux_mode_q && mrx_clk_rise_w) begin
      mrx_cnt_q <= mrx_next_w;
      mrx_out_q <= mrx_bit_w;
    end
  end

  assign mux_rx_serial_out = mrx_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // mux transmit stream: slot counter on the mux transmit clock, restarted by the channel one frame pulse pin
  logic [E1BTI_MUX_W-1:0] mtx_cnt_q;
  logic [E1BTI_MUX_W-1:0] mtx_next_w;
  logic mtx_fp_q, mtx_lead_w;

  // channel one frame pulse pin doubles as the mux transmit frame pulse
  assign mtx_lead_w = tfp_w[0] && !mtx_fp_q;
  assign mtx_next_w = mtx_lead_w ? E1BTI_MUX_RST : mtx_cnt_q + 11'h001;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mtx_cnt_q <= E1BTI_MUX_RST;
      mtx_fp_q <= 1'b0;
    end else if (mux_mode_q && mtx_clk_rise_w) begin
      mtx_cnt_q <= mtx_next_w;
      mtx_fp_q <= tfp_w[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel receive timing and transmit capture
  logic [3:0] rx_rise_w;
  logic [3:0] rfp_prev_q;
  logic [3:0] tfp_prev_q;

  for (genvar c = 0; c < E1BTI_NCH; c++) begin : g_ch
    logic rx_lead_w, tx_lead_w, mrx_slot_w, mtx_slot_w;
    logic [7:0] rx_pos_n_w, tx_pos_n_w;

    // one shared gapped clock unless use_rec_w (line timed with RXREC set) picks each channel's recovered clock
    assign rx_rise_w[c] = use_rec_w ? rec_rise_w[c] : rclk_rise_w;
    assign rx_lead_w = rfp_w && !rfp_prev_q[c];
    assign rx_pos_n_w = rx_lead_w ? E1BTI_POS_RST
                                  : rx_bit_pos[c] + 8'h01;
    assign mrx_slot_w = mrx_clk_rise_w && mrx_next_w[1:0] == 2'(c)
                        && !mrx_next_w[E1BTI_SLOT_SIG];
    // a frame pulse held at one level restarts the count at most once, on the first clock rise after reset
    assign tx_lead_w = tfp_w[c] && !tfp_prev_q[c];
    assign tx_pos_n_w = tx_lead_w ? E1BTI_POS_RST
                                  : tx_bit_pos[c] + 8'h01;
    assign mtx_slot_w = mtx_clk_rise_w && mtx_next_w[1:0] == 2'(c);

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        rx_bit_pos[c] <= E1BTI_POS_RST;
        rx_bit_strobe[c] <= 1'b0;
        rfp_prev_q[c] <= 1'b0;
        rx_aligned_q[c] <= 1'b0;
      end else begin
        rx_bit_strobe[c] <= 1'b0;
        if (mux_mode_q) begin
          if (mrx_slot_w) begin
            rx_bit_pos[c] <= mrx_next_w[E1BTI_MUX_W-1:3];
            rx_bit_strobe[c] <= 1'b1;
          end
        end else if (rx_rise_w[c]) begin
          // no edge, no advance: gaps keep the frame position
          rx_bit_pos[c] <= rx_pos_n_w;
          rx_bit_strobe[c] <= 1'b1;
          rfp_prev_q[c] <= rfp_w;
          if (rx_lead_w) begin
            rx_aligned_q[c] <= 1'b1;
          end
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        tx_bit_pos[c] <= E1BTI_POS_RST;
        tx_strobe[c] <= 1'b0;
        tx_data[c] <= 1'b0;
        tx_sig[c] <= 1'b0;
        tfp_prev_q[c] <= 1'b0;
        tx_aligned_q[c] <= 1'b0;
      end else begin
        tx_strobe[c] <= 1'b0;
        if (mux_mode_q) begin
          // only the channel one data pin is read here
          if (mtx_slot_w && !mtx_next_w[E1BTI_SLOT_SIG]) begin
            tx_data[c] <= pcm_w[0];
            tx_bit_pos[c] <= mtx_next_w[E1BTI_MUX_W-1:3];
          end
          if (mtx_slot_w && mtx_next_w[E1BTI_SLOT_SIG]) begin
            tx_sig[c] <= pcm_w[0];
            tx_strobe[c] <= 1'b1;
          end
          if (mtx_clk_rise_w && mtx_lead_w) begin
            tx_aligned_q[c] <= 1'b1;
          end
        end else if (tclk_rise_w[c]) begin
          tfp_prev_q[c] <= tfp_w[c];
          tx_bit_pos[c] <= tx_pos_n_w;
          if (tx_lead_w) begin
            tx_aligned_q[c] <= 1'b1;
          end
          if (!dual_w) begin
            tx_data[c] <= pcm_w[c];
            tx_sig[c] <= sig_w[c];
            tx_strobe[c] <= 1'b1;
          end
        end
      end
    end

    // dual rail goes straight to the jitter attenuator, not the transmitter
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        dj_strobe[c] <= 1'b0;
        dj_pos_rail[c] <= 1'b0;
        dj_neg_rail[c] <= 1'b0;
      end else begin
        dj_strobe[c] <= 1'b0;
        if (!mux_mode_q && dual_w && tclk_rise_w[c]) begin
          dj_pos_rail[c] <= pcm_w[c];
          dj_neg_rail[c] <= neg_w[c];
          dj_strobe[c] <= 1'b1;
        end
      end
    end

    a_rx_gap_hold: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !mux_mode_q && !rx_rise_w[c] |=> $stable(rx_bit_pos[c]))
      else $error("receive position moved without a clock edge");

    a_tx_single_take: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !mux_mode_q && !dual_w && tclk_rise_w[c]
      |=> tx_strobe[c] && tx_data[c] == $past(pcm_w[c]))
      else $error("single-rail data not taken on clock rise");

    a_dual_bypass: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !mux_mode_q && dual_w && tclk_rise_w[c]
      |=> dj_strobe[c] && !tx_strobe[c] && dj_neg_rail[c] == $past(neg_w[c]))
      else $error("dual-rail bits not passed to jitter attenuator");
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on mode and mux stream behaviour
  a_mux_blocked: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    line_timed_w |=> !mux_mode_q)
    else $error("mux mode active while line timed");

  a_rec_clock_sel: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !mux_mode_q && use_rec_w && !rec_rise_w[0] |=> !rx_bit_strobe[0])
    else $error("receive advanced without recovered clock edge");

  a_neg_ignored: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    mux_mode_q [*2] |=> dj_strobe == 4'h0)
    else $error("negative rail used in mux mode");

  a_mux_no_strobe: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    mux_mode_q && !mtx_clk_rise_w |=> tx_strobe == 4'h0)
    else $error("transmit strobe without mux clock edge");

  a_mux_tx_align: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    mux_mode_q && mtx_clk_rise_w && mtx_lead_w
    |=> mtx_cnt_q == E1BTI_MUX_RST ##1 mtx_fp_q)
    else $error("mux transmit count not aligned to frame pulse");

  a_mux_rx_align: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    mux_mode_q && mrx_clk_rise_w && mrfp_w
    |=> mrx_cnt_q == E1BTI_MUX_RST
        && mrx_out_q == $past(rx_pcm_data[0]))
    else $error("mux receive stream not restarted by frame pulse");

  a_mux_rx_hold: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !mrx_clk_rise_w |=> $stable(mrx_out_q) && $stable(mrx_cnt_q))
    else $error("mux receive output moved off the clock rise");
endmodule : e1bti_top

// [testbench/e1bti_bp_model.sv]
// backplane model: link clock, frame pulse and channel data
module e1bti_bp_model (
  input wire logic run,
  input wire logic hold,
  input wire logic mux,
  output logic lclk,
  output logic fp,
  output logic [11:0] dat
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int flen;
  assign flen = mux ? 2048 : 256;
  // the clock stands low while stopped or held: a gap is missing edges
  initial begin
    lclk = 1'b0;
    fp = 1'b1;
    cnt = 0;
    dat = 12'h000;
    #137;
    forever begin
      #400;
      if (!run) begin
        lclk = 1'b0;
        cnt = 0;
        fp = 1'b1;
      end else if (lclk) begin
        lclk = 1'b0;
        cnt = cnt + 1;
        fp = (cnt % flen) == 0;
        dat = 12'($urandom);
      end else if (!hold) begin
        lclk = 1'b1;
      end
    end
  end
endmodule : e1bti_bp_model

// [testbench/e1bti_top_test.sv]
// self-checking bench for the backplane timing and transmit inputs
module e1bti_top_test;
  import e1bti_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, mux_enable_n, mux_rx_serial_out, mux_mode;
  logic [3:0] rx_pcm_data, rx_sig_data, rx_bit_strobe, tx_strobe;
  logic [3:0] tx_data, tx_sig, dj_strobe, dj_pos_rail, dj_neg_rail;
  logic [3:0][7:0] rx_bit_pos, tx_bit_pos;
  logic run, hold, lclk, fp;
  logic [11:0] dat;
  logic mp [4];
  int bad_count, n_tests, km, nrec, mode;
  int cyc = 0;
  int mk = -1;
  int tq [4][$];
  int rq [4][$];
  int dq [4][$];
  //////////////////////////////////////////////////////////////////////
  e1bti_bp_model bp (.run(run), .hold(hold), .mux(mode == 3),
    .lclk(lclk), .fp(fp), .dat(dat));
  e1bti_top uut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mux_enable_n(mux_enable_n), .bp_rx_clock(mode == 2 ? 1'b0 : lclk),
    .bp_rx_frame_pulse_in(fp), .mux_rx_clock(lclk),
    .mux_rx_frame_pulse(fp),
    .recovered_line_clock_out(mode == 2 ? {4{lclk}} : 4'h0),
    .rx_pcm_data(rx_pcm_data), .rx_sig_data(rx_sig_data),
    .bp_tx_clock({4{lclk}}), .bp_tx_pcm_in(dat[3:0]),
    .bp_tx_signaling_in(dat[7:4]), .bp_tx_neg_rail(dat[11:8]),
    .bp_tx_frame_pulse({4{fp}}), .mux_tx_clock(lclk),
    .mux_rx_serial_out(mux_rx_serial_out), .mux_mode(mux_mode),
    .rx_bit_strobe(rx_bit_strobe), .rx_bit_pos(rx_bit_pos),
    .tx_strobe(tx_strobe), .tx_data(tx_data), .tx_sig(tx_sig),
    .tx_bit_pos(tx_bit_pos), .dj_strobe(dj_strobe),
    .dj_pos_rail(dj_pos_rail), .dj_neg_rail(dj_neg_rail));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  function automatic int pop(input int w, input int c);
    int v;
    v = -1;
    if (w == 0 && tq[c].size() > 0) v = tq[c].pop_front();
    if (w == 1 && rq[c].size() > 0) v = rq[c].pop_front();
    if (w == 2 && dq[c].size() > 0) v = dq[c].pop_front();
    return v;
  endfunction : pop
  // one apb transfer; a hang is left to the bench timeout
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    chk("pready_wait", 1, n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // run n link bits with a gap halfway, then drain and check queues
  task automatic phase(int m, int n);
    @(posedge sys_clk);
    mode <= m;
    run <= 1'b1;
    repeat (n / 2) @(posedge lclk);
    @(posedge sys_clk);
    hold <= 1'b1;
    repeat (40) @(posedge sys_clk);
    hold <= 1'b0;
    repeat (n - n / 2) @(posedge lclk);
    @(posedge sys_clk);
    run <= 1'b0;
    repeat (30) @(posedge sys_clk);
    for (int c = 0; c < 4; c++)
      chk("qlen", 0, tq[c].size() + rq[c].size() + dq[c].size());
  endtask : phase
  //////////////////////////////////////////////////////////////////////
  // reference model, one step per link edge actually present
  always @(posedge lclk) begin : model
    int c;
    logic b;
    // the previous mux slot's bit still stands when this edge arrives
    b = mk % 8 < 4 ? rx_pcm_data[mk % 4] : rx_sig_data[mk % 4];
    if (mode == 3 && mk >= 0)
      chk("mrd_slot", b, mux_rx_serial_out);
    km = fp ? 0 : (km + 1) % 2048;
    c = km % 4;
    if (mode == 3) begin
      mk = km;
      if (km % 8 < 4) begin
        mp[c] = dat[0];
        rq[c].push_back(km / 8);
      end else tq[c].push_back(km / 8 * 4 + dat[0] * 2 + mp[c]);
    end else for (c = 0; c < 4; c++) begin
      if (mode == 1) dq[c].push_back(dat[8 + c] * 2 + dat[c]);
      else tq[c].push_back(km % 256 * 4 + dat[4 + c] * 2 + dat[c]);
      if (mode < 2) rq[c].push_back(km % 256);
    end
  end
  always @(negedge sys_clk) if (resetn) begin
    for (int c = 0; c < 4; c++) begin
      if (tx_strobe[c] === 1'b1)
        chk("tx", pop(0, c), {tx_bit_pos[c], tx_sig[c], tx_data[c]});
      if (dj_strobe[c] === 1'b1)
        chk("dj", pop(2, c), {dj_neg_rail[c], dj_pos_rail[c]});
      if (rx_bit_strobe[c] === 1'b1 && mode == 2) nrec++;
      else if (rx_bit_strobe[c] === 1'b1)
        chk("rx", pop(1, c), rx_bit_pos[c]);
      if (rx_bit_strobe[c] === 1'b1 && mode == 3)
        chk("mrd", rx_pcm_data[c], mux_rx_serial_out);
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // a hang ends in the closing report
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(32'h4e56));
    {resetn, psel, penable, pwrite, run, hold} = 6'h00;
    {paddr, pwdata, rx_pcm_data, rx_sig_data} = 48'h0;
    mux_enable_n = 1'b1;
    {mode, km, nrec, bad_count, n_tests} = 160'h0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(0, E1BTI_CTRL_ADDR, 0);
    chk("ctrl_rst", {28'h0, E1BTI_CTRL_RST}, r);
    apb(1, E1BTI_CTRL_ADDR, 32'hffff_ffff);
    apb(0, E1BTI_CTRL_ADDR, 0);
    chk("ctrl_rw", 32'h0000_000f, r);
    apb(1, 8'h0c, 32'hffff_ffff);
    chk("slverr", 1, e);
    apb(0, 8'h0c, 0);
    chk("unmapped", 0, r);
    apb(1, E1BTI_CTRL_ADDR, 0);
    phase(0, 300);
    apb(1, E1BTI_CTRL_ADDR, 32'h0000_0008);
    phase(1, 40);
    apb(1, E1BTI_CTRL_ADDR, 32'h0000_0005);
    mux_enable_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("mux_off", 0, mux_mode);
    apb(0, E1BTI_STAT_ADDR, 0);
    chk("stat_mux", 0, r[E1BTI_STAT_MUX]);
    phase(2, 40);
    chk("nrec", 160, nrec);
    apb(1, E1BTI_CTRL_ADDR, 0);
    rx_pcm_data <= 4'($urandom);
    rx_sig_data <= 4'($urandom);
    repeat (8) @(posedge sys_clk);
    chk("mux_on", 1, mux_mode);
    phase(3, 2100);
    finish_test;
  end
endmodule : e1bti_top_test
